// >>> prs_pkg.sv
package prs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices on the port bus
   localparam int unsigned ADDR_W = 3;
   localparam logic [2:0] OFF_KSCAN = 3'h0;
   localparam logic [2:0] OFF_KEYIN = 3'h1;
   localparam logic [2:0] OFF_PTR = 3'h3;
   localparam logic [2:0] OFF_MODE = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] KSCAN_RST = 8'hFF;
   localparam logic [7:0] MODE_RST = 8'h26;
   localparam logic [3:0] PTR_RST = 4'h0;
   localparam logic [7:0] MODE_NO_SD_MASK = 8'h3F;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions: pointer / retention register
   localparam int unsigned PTR_LSB = 4;
   localparam int unsigned RET_BIT = 3;

   // Field positions: mode control register
   localparam int unsigned MODE_SA = 0;
   localparam int unsigned MODE_KSCAN = 1;
   localparam int unsigned MODE_IND = 2;
   localparam int unsigned MODE_WAKE = 3;
   localparam int unsigned MODE_AB_PD = 4;
   localparam int unsigned MODE_KI_PD = 5;
   localparam int unsigned MODE_SD_PD = 6;
   localparam int unsigned MODE_SD = 7;

   // Field positions: key input / sense register
   localparam int unsigned KEYIN_SD = 0;
   localparam int unsigned KEYIN_WAKE = 1;
   localparam int unsigned KEYIN_SA = 2;
   localparam int unsigned KEYIN_IND = 3;
   localparam int unsigned KEYIN_KI = 4;

   function automatic logic prs_hit(input logic [2:0] a, input logic [2:0] off);
      return a == off;
   endfunction : prs_hit

endpackage : prs_pkg

// >>> prs_ctrl_if.sv
interface prs_ctrl_if;
   logic [7:0] mode;
   logic [7:0] wdata;
   logic kscan_wr;
   logic [7:0] kscan_rd;
   logic [7:0] keyin_rd;

   modport ctrl (output mode, output wdata, output kscan_wr,
                 input kscan_rd, input keyin_rd);
   modport kscan (input mode, input wdata, input kscan_wr, output kscan_rd);
   modport sense (input mode, output keyin_rd);
endinterface : prs_ctrl_if

// >>> prs_kscan.sv
module prs_kscan (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Control
   prs_ctrl_if.kscan bus,
   // Pins
   input wire logic [7:0] i_key_scan_io,
   output logic [7:0] o_key_scan_io,
   output logic [7:0] o_key_scan_io_oe
);
   logic [7:0] latch_r;
   logic out_mode;

   assign out_mode = bus.mode[prs_pkg::MODE_KSCAN];

   // Latch takes writes in either mode
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         latch_r <= prs_pkg::KSCAN_RST;
      else if (bus.kscan_wr)
         latch_r <= bus.wdata;
   end

   assign bus.kscan_rd = out_mode ? latch_r : i_key_scan_io;
   assign o_key_scan_io = latch_r;
   assign o_key_scan_io_oe = {8{out_mode}};
endmodule : prs_kscan

// >>> prs_sense.sv
module prs_sense #(
   parameter bit HAS_SENSE_D = 1'b1
) (
   // Control
   prs_ctrl_if.sense bus,
   // Pins
   input wire logic [3:0] i_key_input,
   input wire logic i_sense_a,
   input wire logic i_sense_b_indicator,
   input wire logic i_stop_wake_input,
   input wire logic i_sense_d
);
   logic sa_bit;
   logic sd_bit;

   // Off mode keeps the pin isolated, so a fixed level is returned
   assign sa_bit = bus.mode[prs_pkg::MODE_SA] ? i_sense_a : 1'b1;
   assign sd_bit = HAS_SENSE_D ? (bus.mode[prs_pkg::MODE_SD] & i_sense_d)
                               : 1'b1;

   assign bus.keyin_rd = {i_key_input, i_sense_b_indicator, sa_bit,
                          i_stop_wake_input, sd_bit};
endmodule : prs_sense

// >>> prs_port_regs.sv
// What this block does
// - Key-scan, key input, sense pins and both control registers are bus registers.
// - Reset loads defined values; key-scan data becomes all ones.
// - Key input, stop-wake and indicator reads show live pin levels after reset; sense_a and sense_d start off.
// - Control 0 resets to 0000x000; x is 0 after supply dropped too low.
// - Control 0 holds pointer bits 11..8 in 7..4, retention flag bit 3.
// - Control 1 holds mode, pull-down and stop-wake enables in fixed order.
// - Control 1 resets to 26 hex: key pull-down, indicator and key-scan out.
// - Key-scan writes always hit latch; reads give pins in, latch out.
// - Key input and stop-wake bits are read-only pin levels.
// - Sense_a reads 1 when off, pin level when input.
// - Sense_d reads 0 when off, pin level when input.
// - Indicator bit reads the pin level in both directions.
// - After reset key-scan port is output with latch all ones.
//
// The register offsets and the address-and-strobe port were left to the implementer.
module prs_port_regs #(
   parameter bit HAS_SENSE_D = 1'b1
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,

   // Register port
   input wire logic [prs_pkg::ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic o_rdata_valid,

   // Supply monitor
   input wire logic i_retention_lost,

   // Key-scan port pins
   input wire logic [7:0] i_key_scan_io,
   output logic [7:0] o_key_scan_io,
   output logic [7:0] o_key_scan_io_oe,
   output logic o_key_scan_pd,

   // Key input and sense pins
   input wire logic [3:0] i_key_input,
   input wire logic i_sense_a,
   input wire logic i_stop_wake_input,
   input wire logic i_sense_d,
   output logic o_key_input_pd,
   output logic o_sense_a_pd,
   output logic o_stop_wake_pd,
   output logic o_stop_wake_release_en,
   output logic o_sense_d_pd,

   // Indicator pin
   input wire logic i_sense_b_indicator,
   output logic o_sense_b_indicator,
   output logic o_sense_b_indicator_oe,
   output logic o_indicator_pd,

   // Core side
   output logic [3:0] o_table_pointer_hi,
   output logic o_retention_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic hit_kscan;
   logic hit_keyin;
   logic hit_ptr;
   logic hit_mode;
   logic [7:0] mode_mask;
   logic [7:0] rd_mux;

   assign hit_kscan = prs_pkg::prs_hit(i_addr, prs_pkg::OFF_KSCAN);
   assign hit_keyin = prs_pkg::prs_hit(i_addr, prs_pkg::OFF_KEYIN);
   assign hit_ptr = prs_pkg::prs_hit(i_addr, prs_pkg::OFF_PTR);
   assign hit_mode = prs_pkg::prs_hit(i_addr, prs_pkg::OFF_MODE);
   assign mode_mask = HAS_SENSE_D ? 8'hFF : prs_pkg::MODE_NO_SD_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   logic [3:0] ptr_r;
   logic ret_r;
   logic [7:0] mode_r;
   logic [7:0] rdata_r;
   logic rvalid_r;

   // Sync reset lets the supply monitor level be caught on the reset cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         ptr_r <= prs_pkg::PTR_RST;
         ret_r <= ~i_retention_lost;
      end
      else if (i_wr && hit_ptr)
      begin
         ptr_r <= i_wdata[prs_pkg::PTR_LSB +: 4];
         ret_r <= i_wdata[prs_pkg::RET_BIT];
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         mode_r <= prs_pkg::MODE_RST & mode_mask;
      else if (i_wr && hit_mode)
         mode_r <= i_wdata & mode_mask;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port leaves
   prs_ctrl_if cif ();

   assign cif.mode = mode_r;
   assign cif.wdata = i_wdata;
   assign cif.kscan_wr = i_wr & hit_kscan;

   prs_kscan u_kscan (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .bus(cif),
      .i_key_scan_io(i_key_scan_io),
      .o_key_scan_io(o_key_scan_io),
      .o_key_scan_io_oe(o_key_scan_io_oe)
   );

   prs_sense #(
      .HAS_SENSE_D(HAS_SENSE_D)
   ) u_sense (
      .bus(cif),
      .i_key_input(i_key_input),
      .i_sense_a(i_sense_a),
      .i_sense_b_indicator(i_sense_b_indicator),
      .i_stop_wake_input(i_stop_wake_input),
      .i_sense_d(i_sense_d)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read path; unmapped indices read zero, key input ignores writes
   assign rd_mux = hit_kscan ? cif.kscan_rd :
                   hit_keyin ? cif.keyin_rd :
                   hit_ptr ? {ptr_r, ret_r, 3'h0} :
                   hit_mode ? mode_r :
                   8'h00;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r <= i_rd ? rd_mux : 8'h00;
         rvalid_r <= i_rd;
      end
   end

   assign o_rdata = rdata_r;
   assign o_rdata_valid = rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Pin controls
   assign o_key_scan_pd = ~mode_r[prs_pkg::MODE_KSCAN];
   assign o_key_input_pd = mode_r[prs_pkg::MODE_KI_PD];
   assign o_sense_a_pd = mode_r[prs_pkg::MODE_AB_PD] & mode_r[prs_pkg::MODE_SA];
   assign o_indicator_pd = mode_r[prs_pkg::MODE_AB_PD] & ~mode_r[prs_pkg::MODE_IND];
   assign o_sense_d_pd = mode_r[prs_pkg::MODE_SD_PD] & mode_r[prs_pkg::MODE_SD];
   assign o_stop_wake_release_en = mode_r[prs_pkg::MODE_WAKE];
   // Pull-down on the wake pin follows its release enable
   assign o_stop_wake_pd = mode_r[prs_pkg::MODE_WAKE];
   // Timer pulse not modelled here: output mode drives a steady high
   assign o_sense_b_indicator = 1'b1;
   assign o_sense_b_indicator_oe = mode_r[prs_pkg::MODE_IND];
   assign o_table_pointer_hi = ptr_r;
   assign o_retention_flag = ret_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   AST_RD_LATENCY: assert property (
      i_rd |=> o_rdata_valid ##1 !o_rdata_valid || $past(i_rd))
      else $error("read data not valid for exactly the cycle after a read");

   AST_KSCAN_RESET: assert property (
      $past(i_reset) |->
         o_key_scan_io == prs_pkg::KSCAN_RST && o_key_scan_io_oe == 8'hFF)
      else $error("key-scan port not output with latch all ones after reset");

   AST_PTR_RESET: assert property (
      $past(i_reset) |->
         o_table_pointer_hi == prs_pkg::PTR_RST &&
         o_retention_flag == !$past(i_retention_lost))
      else $error("control 0 reset value wrong");

   AST_MODE_RESET: assert property (
      $past(i_reset) |->
         mode_r == (prs_pkg::MODE_RST & mode_mask) && o_key_input_pd &&
         o_sense_b_indicator_oe && !o_stop_wake_release_en)
      else $error("control 1 reset value wrong");

   AST_KEYIN_READ: assert property (
      i_rd && hit_keyin |=>
         o_rdata[prs_pkg::KEYIN_KI +: 4] == $past(i_key_input) &&
         o_rdata[prs_pkg::KEYIN_WAKE] == $past(i_stop_wake_input))
      else $error("key input read does not show pin levels");

   AST_KEYIN_NOWRITE: assert property (
      i_wr && hit_keyin |=> $stable(mode_r) && $stable(ptr_r) &&
         $stable(o_key_scan_io))
      else $error("write to key input register changed state");

   AST_KSCAN_WRITE: assert property (
      i_wr && hit_kscan |=> o_key_scan_io == $past(i_wdata))
      else $error("key-scan write did not reach the latch");

   AST_KSCAN_READ: assert property (
      i_rd && hit_kscan |=> o_rdata == ($past(mode_r[prs_pkg::MODE_KSCAN]) ?
         $past(o_key_scan_io) : $past(i_key_scan_io)))
      else $error("key-scan read source wrong for mode");

   AST_SENSE_A: assert property (
      i_rd && hit_keyin |=> o_rdata[prs_pkg::KEYIN_SA] ==
         ($past(mode_r[prs_pkg::MODE_SA]) ? $past(i_sense_a) : 1'b1))
      else $error("sense_a read value wrong");

   AST_SENSE_D: assert property (
      i_rd && hit_keyin |=> o_rdata[prs_pkg::KEYIN_SD] == (HAS_SENSE_D ?
         ($past(mode_r[prs_pkg::MODE_SD]) & $past(i_sense_d)) : 1'b1))
      else $error("sense_d read value wrong");

   AST_IND_READ: assert property (
      i_rd && hit_keyin |=>
         o_rdata[prs_pkg::KEYIN_IND] == $past(i_sense_b_indicator))
      else $error("indicator read does not show the pin");

   AST_PTR_FIELDS: assert property (
      i_wr && hit_ptr ##1 i_rd && hit_ptr |=>
         o_rdata[7:4] == $past(i_wdata[7:4], 2) &&
         o_rdata[prs_pkg::RET_BIT] == $past(i_wdata[prs_pkg::RET_BIT], 2) &&
         o_rdata[2:0] == 3'h0)
      else $error("control 0 layout wrong on readback");

   AST_MODE_MASK: assert property (
      i_wr && hit_mode |=> mode_r == ($past(i_wdata) & mode_mask) &&
         o_sense_b_indicator_oe == $past(i_wdata[prs_pkg::MODE_IND]))
      else $error("control 1 write not stored as masked");

   AST_NO_SD_BITS: assert property (
      !HAS_SENSE_D |-> mode_r[7:6] == 2'h0 && !o_sense_d_pd)
      else $error("control 1 upper bits set without sense_d");

   AST_RDATA_IDLE: assert property (
      !$past(i_rd) |-> o_rdata == 8'h00 && !o_rdata_valid)
      else $error("read data not zero outside the cycle after a read");

   AST_UNMAPPED_READ: assert property (
      i_rd && !(hit_kscan || hit_keyin || hit_ptr || hit_mode) |=> o_rdata == 8'h00)
      else $error("read of an unmapped index not zero");

   // Any other index, unmapped ones too, must leave a register alone
   AST_KSCAN_HOLD: assert property (
      !(i_wr && hit_kscan) |=> $stable(o_key_scan_io))
      else $error("key-scan latch changed without a write to it");

   AST_PTR_HOLD: assert property (
      !(i_wr && hit_ptr) |=> $stable(ptr_r) && $stable(ret_r))
      else $error("control 0 changed without a write to it");

   AST_MODE_HOLD: assert property (
      !(i_wr && hit_mode) |=> $stable(mode_r))
      else $error("control 1 changed without a write to it");

   AST_KSCAN_DIR: assert property (
      o_key_scan_io_oe == {8{mode_r[prs_pkg::MODE_KSCAN]}} &&
      o_key_scan_pd == !mode_r[prs_pkg::MODE_KSCAN])
      else $error("key-scan direction or pull-down does not follow its mode bit");

   // Pull-downs would fight a driven or isolated pin
   AST_PD_INPUT_ONLY: assert property (
      !(o_indicator_pd && o_sense_b_indicator_oe) &&
      (!o_sense_a_pd || mode_r[prs_pkg::MODE_SA]) &&
      (!o_sense_d_pd || mode_r[prs_pkg::MODE_SD]))
      else $error("pull-down enabled on a pin not in input mode");

   AST_PD_SELECT: assert property (
      o_key_input_pd == mode_r[prs_pkg::MODE_KI_PD] &&
      o_stop_wake_pd == mode_r[prs_pkg::MODE_WAKE] &&
      o_stop_wake_release_en == mode_r[prs_pkg::MODE_WAKE] &&
      o_sense_a_pd == (mode_r[prs_pkg::MODE_AB_PD] && mode_r[prs_pkg::MODE_SA]))
      else $error("pull-down or release enable does not follow control 1");

   COV_KSCAN_IN_READ: cover property (
      i_rd && hit_kscan && !mode_r[prs_pkg::MODE_KSCAN]);
   COV_KEYIN_READ: cover property (i_rd && hit_keyin);
   COV_MODE_WRITE: cover property (i_wr && hit_mode);
   COV_WR_THEN_RD: cover property (i_wr && hit_kscan ##1 i_rd && hit_kscan);
   COV_SD_INPUT_READ: cover property (i_rd && hit_keyin && mode_r[prs_pkg::MODE_SD]);

endmodule : prs_port_regs

// >>> prs_key_model.sv
module prs_key_model (
   // Device side of the key-scan port and indicator
   input wire logic [7:0] i_scan_drive,
   input wire logic [7:0] i_scan_oe,
   input wire logic i_ind_drive,
   input wire logic i_ind_oe,
   // Key matrix and indicator levels chosen by the bench
   input wire logic [7:0] i_keys,
   input wire logic i_ind_ext,
   // Resolved pin levels
   output logic [7:0] o_scan_pin,
   output logic o_ind_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   // Driven bits win; released bits show the key matrix, so a read in
   // input mode shows the keys, which differ from the latch
   assign o_scan_pin = (i_scan_drive & i_scan_oe) | (i_keys & ~i_scan_oe);
   assign o_ind_pin = i_ind_oe ? i_ind_drive : i_ind_ext;
endmodule : prs_key_model

// >>> testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic wr;
      logic [2:0] wa;
      logic [7:0] wd;
      logic [2:0] ra;
      logic [7:0] keys;
      logic [3:0] ki;
      logic ind;
      logic sa;
      logic wake;
      logic sd;
      logic [7:0] exp1;
      logic [7:0] exp0;
   } prs_tb_row_t;

   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, keys = 8'h00;
   logic wr = 1'b0, rd = 1'b0, ret_lost = 1'b1;
   logic [3:0] ki = 4'h0;
   logic ind_ext = 1'b0, sa = 1'b0, wake = 1'b0, sd = 1'b0;
   logic [7:0] rdata, rdata0, kscan_pin, kscan_o, kscan_oe;
   logic valid, kscan_pd, ki_pd, sw_en, ind_pin, ind_o, ind_oe, ret_flag;
   logic [3:0] tp_hi;
   logic sa_pd, sw_pd, sd_pd, ind_pd, sd_pd0;
   int err_total = 0;
   int num_checks = 0;

   // Second copy is the variant without sense_d; it shares every input
   prs_tb_row_t rows [11] = '{
      '{1, 0, 8'h5A, 0, 8'h00, 4'h0, 0, 0, 0, 0, 8'h5A, 8'h5A},
      '{1, 4, 8'h24, 0, 8'h3C, 4'h0, 0, 0, 0, 0, 8'h3C, 8'h3C},
      '{1, 0, 8'hA5, 0, 8'h3C, 4'h0, 0, 0, 0, 0, 8'h3C, 8'h3C},
      '{1, 4, 8'h26, 0, 8'h3C, 4'h0, 0, 0, 0, 0, 8'hA5, 8'hA5},
      '{0, 0, 8'h00, 1, 8'h00, 4'hA, 0, 0, 1, 1, 8'hAE, 8'hAF},
      '{1, 4, 8'h81, 1, 8'h00, 4'h5, 0, 0, 0, 1, 8'h51, 8'h51},
      '{0, 0, 8'h00, 1, 8'h00, 4'hF, 1, 1, 1, 0, 8'hFE, 8'hFF},
      '{1, 1, 8'h00, 1, 8'h00, 4'hF, 1, 1, 1, 0, 8'hFE, 8'hFF},
      '{1, 3, 8'hAF, 3, 8'h00, 4'h0, 0, 0, 0, 0, 8'hA8, 8'hA8},
      '{1, 4, 8'h5A, 4, 8'h00, 4'h0, 0, 0, 0, 0, 8'h5A, 8'h1A},
      '{1, 6, 8'hFF, 2, 8'h00, 4'h0, 0, 0, 0, 0, 8'h00, 8'h00}
   };

   always #10 i_ref_clk = ~i_ref_clk;

   prs_port_regs #(.HAS_SENSE_D(1'b1)) i_prs_port_regs (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rdata_valid(valid),
      .i_retention_lost(ret_lost), .i_key_scan_io(kscan_pin), .o_key_scan_io(kscan_o),
      .o_key_scan_io_oe(kscan_oe), .o_key_scan_pd(kscan_pd), .i_key_input(ki),
      .i_sense_a(sa), .i_stop_wake_input(wake), .i_sense_d(sd), .o_key_input_pd(ki_pd),
      .o_sense_a_pd(sa_pd), .o_stop_wake_pd(sw_pd), .o_stop_wake_release_en(sw_en),
      .o_sense_d_pd(sd_pd), .i_sense_b_indicator(ind_pin), .o_sense_b_indicator(ind_o),
      .o_sense_b_indicator_oe(ind_oe), .o_indicator_pd(ind_pd),
      .o_table_pointer_hi(tp_hi), .o_retention_flag(ret_flag));

   prs_port_regs #(.HAS_SENSE_D(1'b0)) i_prs_port_regs_nsd (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata0), .o_rdata_valid(),
      .i_retention_lost(ret_lost), .i_key_scan_io(kscan_pin), .o_key_scan_io(),
      .o_key_scan_io_oe(), .o_key_scan_pd(), .i_key_input(ki),
      .i_sense_a(sa), .i_stop_wake_input(wake), .i_sense_d(sd), .o_key_input_pd(),
      .o_sense_a_pd(), .o_stop_wake_pd(), .o_stop_wake_release_en(),
      .o_sense_d_pd(sd_pd0), .i_sense_b_indicator(ind_pin), .o_sense_b_indicator(),
      .o_sense_b_indicator_oe(), .o_indicator_pd(),
      .o_table_pointer_hi(), .o_retention_flag());

   prs_key_model i_prs_key_model (
      .i_scan_drive(kscan_o), .i_scan_oe(kscan_oe), .i_ind_drive(ind_o),
      .i_ind_oe(ind_oe), .i_keys(keys), .i_ind_ext(ind_ext),
      .o_scan_pin(kscan_pin), .o_ind_pin(ind_pin));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Read follows any pending write strobe with no gap
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e1, input logic [7:0] e0);
      @(posedge i_ref_clk);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge i_ref_clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, e1);
      chk("rdata_nsd", rdata0, e0);
      chk("rdata_valid", {7'h00, valid}, 8'h01);
   endtask : rd_reg

   task automatic do_reset(input logic lost, input logic [7:0] e3);
      @(posedge i_ref_clk);
      i_reset <= 1'b1;
      ret_lost <= lost;
      wr <= 1'b0;
      rd <= 1'b0;
      ki <= 4'h9;
      ind_ext <= 1'b0;
      sa <= 1'b0;
      wake <= 1'b1;
      sd <= 1'b1;
      repeat (20) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      #1;
      chk("scan_oe", kscan_oe, 8'hFF);
      chk("scan_latch", kscan_o, 8'hFF);
      chk("pin_ctl", {ki_pd, ind_oe, sw_en, kscan_pd, 4'h0}, 8'hC0);
      chk("pd_ctl", {sa_pd, sw_pd, sd_pd, ind_pd, 4'h0}, 8'h00);
      rd_reg(3'h3, e3, e3);
      rd_reg(3'h0, 8'hFF, 8'hFF);
      rd_reg(3'h4, 8'h26, 8'h26);
      rd_reg(3'h1, 8'h9E, 8'h9F);
   endtask : do_reset

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      err_total++;
      end_of_test();
   end

   initial
   begin
      do_reset(1'b1, 8'h00);
      foreach (rows[n])
      begin
         @(posedge i_ref_clk);
         keys <= rows[n].keys;
         ki <= rows[n].ki;
         ind_ext <= rows[n].ind;
         sa <= rows[n].sa;
         wake <= rows[n].wake;
         sd <= rows[n].sd;
         wr <= rows[n].wr;
         addr <= rows[n].wa;
         wdata <= rows[n].wd;
         rd_reg(rows[n].ra, rows[n].exp1, rows[n].exp0);
      end
      // Mode 5A: wake release on, key pull-down off, indicator input
      chk("pin_ctl", {ki_pd, ind_oe, sw_en, kscan_pd, 4'h0}, 8'h20);
      chk("ptr_out", {tp_hi, 3'h0, ret_flag}, 8'hA1);
      chk("pd_ctl", {sa_pd, sw_pd, sd_pd, ind_pd, 4'h0}, 8'h50);
      // Sense pins in input mode with their pull-downs enabled; key input and wake pull-downs off
      @(posedge i_ref_clk);
      wr <= 1'b1;
      addr <= 3'h4;
      wdata <= 8'hD1;
      rd_reg(3'h4, 8'hD1, 8'h11);
      chk("pd_ctl", {sa_pd, sw_pd, sd_pd, ind_pd, 4'h0}, 8'hB0);
      chk("sd_pd_nsd", {7'h00, sd_pd0}, 8'h00);
      // Reset again in mid-run, supply now healthy
      do_reset(1'b0, 8'h08);
      end_of_test();
   end
endmodule : testbench
